//--- hdl/dtd_pkg.sv
// dtd_pkg: constants, tables and types for the keypad tone dialer
package dtd_pkg;

   // clock rate
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned CLK_HZ = 250_000_000;

   // key qualification window, least and most, in microseconds
   localparam int unsigned KEY_QUALIFY_TIME_US = 23000;
   localparam int unsigned KEY_QUALIFY_MAX_US = 25300;
   // least time rounds up; an integer product is already exact
   localparam int unsigned KEY_QUALIFY_CYC = KEY_QUALIFY_TIME_US * CLK_MHZ;
   localparam int unsigned KEY_QUALIFY_MAX_CYC = KEY_QUALIFY_MAX_US * CLK_MHZ;

   // scan timing: each half of a scan lets the pins settle this long
   localparam int SCAN_W = 6;
   localparam logic [SCAN_W-1:0] SCAN_LAST = 6'h3F;

   // nominal tones: rows 1..4 then columns 1..4
   localparam int unsigned TONE_HZ [8] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};

   localparam int DIV_W = 18;
   typedef logic [DIV_W-1:0] dtd_half_t [8];

   // half-period counts of each tone, built once from the table above
   function automatic dtd_half_t dtd_build_half();
      dtd_half_t t;
      for (int i = 0; i < 8; i++) begin
         t[i] = DIV_W'(CLK_HZ / (2 * TONE_HZ[i]));
      end
      return t;
   endfunction : dtd_build_half

   localparam dtd_half_t TONE_HALF = dtd_build_half();

   // key code is {row index, column index}; hash sits in row 4, column 3
   localparam logic [3:0] KEY_HASH = 4'hE;
   localparam logic [1:0] COL_FOURTH = 2'h3;

   // kind of entry seen by the last scan
   localparam logic [1:0] KIND_DUAL = 2'h0;
   localparam logic [1:0] KIND_COL = 2'h1;
   localparam logic [1:0] KIND_ROW = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_QUAL = 3'b010,
      ST_TONE = 3'b100
   } dtd_state_t;

   typedef enum logic [1:0] {
      REDIAL_NONE = 2'h0,
      REDIAL_COL4 = 2'h1,
      REDIAL_HASH = 2'h2
   } dtd_redial_t;

endpackage : dtd_pkg

//--- hdl/dtd_keypad_dialer.sv
// dtd_keypad_dialer: keypad sensing, qualification, scan and tone division
//
// What this block does
// - tone-disable low stops oscillator, ignores keypad
// - static keypad until any column is sensed low, then scan
// - accept key only after qualification time
// - mute pulls low when disabled or key sensed
// - single tones only when single-tone enable high
// - rows and columns select standard tone divisors
// - achieved tones within 0.74 percent of nominal
// - redial options none, fourth column, hash
// - decode keys as four by four grid
`timescale 1ns/10ps
`default_nettype none

module dtd_keypad_dialer
   import dtd_pkg::*;
#(
   parameter dtd_redial_t REDIAL_MODE = REDIAL_NONE,
   parameter int unsigned KEY_QUALIFY_CYC_P = KEY_QUALIFY_CYC
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic tone_dis_n_i,
   input wire logic single_tone_en_i,
   input wire logic [3:0] row_n_i,
   input wire logic [3:0] col_n_i,
   output logic [3:0] row_o,
   output logic [3:0] row_oe_o,
   output logic [3:0] col_o,
   output logic [3:0] col_oe_o,
   output logic mute_out_n_o,
   output logic mute_out_n_oe_o,
   output logic osc_run_o,
   output logic row_tone_o,
   output logic col_tone_o,
   output logic row_tone_en_o,
   output logic col_tone_en_o,
   output logic key_valid_o,
   output logic [3:0] key_code_o,
   output logic redial_o
);

   dtd_state_t st_q, st_d;
   logic phase_q;
   logic [SCAN_W-1:0] scan_cnt_q;
   logic [3:0] cols_smp_q;
   logic [31:0] qual_cnt_q;
   logic [3:0] key_code_q;
   logic [1:0] kind_q;
   logic [3:0] row_oe_q, col_oe_q;
   logic mute_oe_q, osc_run_q, key_valid_q, redial_q;
   logic [1:0] tone_en_q;

   // priority encoder for one-hot pin groups
   function automatic logic [1:0] enc4(input logic [3:0] v);
      return v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
   endfunction : enc4

   // decode of the current scan; rows are read while columns are driven
   wire [3:0] rows_act = ~row_n_i;
   wire [2:0] row_cnt = 3'($countones(rows_act));
   wire [2:0] col_cnt = 3'($countones(cols_smp_q));
   wire is_dual = (row_cnt == 3'h1) && (col_cnt == 3'h1);
   wire is_col = (row_cnt == 3'h0) && (col_cnt == 3'h1);
   wire is_row = (row_cnt == 3'h1) && (col_cnt >= 3'h2);
   wire entry_ok = is_dual || is_col || is_row;
   wire [1:0] samp_kind = is_dual ? KIND_DUAL : (is_col ? KIND_COL : KIND_ROW);
   // grid position: row index high, column index low, left to right
   wire [3:0] samp_code = {enc4(rows_act), enc4(cols_smp_q)};
   wire same_key = entry_ok && (samp_code == key_code_q) && (samp_kind == kind_q);
   wire scan_end = (st_q != ST_IDLE) && (scan_cnt_q == SCAN_LAST);
   wire eval = scan_end && phase_q;
   wire qual_done = qual_cnt_q >= (KEY_QUALIFY_CYC_P - 1);
   wire key_sensed = col_n_i != 4'hF;
   // only a real dual key can redial; a single tone entry may carry the code of a redial key
   wire is_redial = (kind_q == KIND_DUAL) &&
                    (((REDIAL_MODE == REDIAL_COL4) && (key_code_q[1:0] == COL_FOURTH)) ||
                    ((REDIAL_MODE == REDIAL_HASH) && (key_code_q == KEY_HASH)));

   // next state; a disabled dialer always falls back to idle
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (key_sensed) begin
               st_d = ST_QUAL;
            end
         end
         ST_QUAL: begin
            if (eval && !entry_ok) begin
               st_d = ST_IDLE;
            end else if (eval && same_key && qual_done) begin
               st_d = ST_TONE;
            end
         end
         ST_TONE: begin
            if (eval && !same_key) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (!tone_dis_n_i) begin
         st_d = ST_IDLE;
      end
   end

   // tone enables: single tones only with the test input high, none for redial keys
   wire single_ok = single_tone_en_i && (kind_q != KIND_DUAL);
   wire tone_on = (st_d == ST_TONE) && !is_redial;
   wire row_en_d = tone_on && ((kind_q == KIND_DUAL) || (single_ok && kind_q == KIND_ROW));
   wire col_en_d = tone_on && ((kind_q == KIND_DUAL) || (single_ok && kind_q == KIND_COL));

   // state, scan timing and samples
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_IDLE;
         phase_q <= 1'b0;
         scan_cnt_q <= '0;
         cols_smp_q <= 4'h0;
      end else begin
         st_q <= st_d;
         scan_cnt_q <= (st_d == ST_IDLE) ? '0 : scan_cnt_q + 1'b1;
         phase_q <= (st_d == ST_IDLE) ? 1'b0 : phase_q ^ scan_end;
         if (scan_end && !phase_q) begin
            cols_smp_q <= ~col_n_i;
         end
      end
   end

   // qualification timer restarts whenever the scanned key changes
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         qual_cnt_q <= 32'h0;
         key_code_q <= 4'h0;
         kind_q <= KIND_DUAL;
      end else if (st_q == ST_IDLE) begin
         qual_cnt_q <= 32'h0;
      end else begin
         if (eval && !same_key) begin
            qual_cnt_q <= 32'h0;
            key_code_q <= samp_code;
            kind_q <= samp_kind;
         end else if (!qual_done) begin
            qual_cnt_q <= qual_cnt_q + 32'h1;
         end
      end
   end

   // pin drive, only while tone-disable is high: rows low while idle and in the first scan half, columns low in the second
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         row_oe_q <= 4'h0;
         col_oe_q <= 4'h0;
      end else begin
         row_oe_q <= {4{tone_dis_n_i && (st_d == ST_IDLE || !(phase_q ^ scan_end))}};
         col_oe_q <= {4{tone_dis_n_i && st_d != ST_IDLE && (phase_q ^ scan_end)}};
      end
   end

   // status outputs; mute counts a key as sensed from first detection on
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mute_oe_q <= 1'b0;
         osc_run_q <= 1'b0;
         key_valid_q <= 1'b0;
         redial_q <= 1'b0;
         tone_en_q <= 2'h0;
      end else begin
         mute_oe_q <= !tone_dis_n_i || (st_d != ST_IDLE);
         osc_run_q <= tone_dis_n_i && (st_d != ST_IDLE);
         key_valid_q <= st_d == ST_TONE;
         redial_q <= (st_q == ST_QUAL) && (st_d == ST_TONE) && is_redial;
         tone_en_q <= {col_en_d, row_en_d};
      end
   end

   // tone dividers; truncated counts from the fast clock keep error far below the limit
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_div
         logic [DIV_W-1:0] cnt_q;
         logic tone_q;
         wire [1:0] idx = (g == 0) ? key_code_q[3:2] : key_code_q[1:0];
         localparam logic [0:0] SIDE = 1'(g);
         wire [DIV_W-1:0] half = TONE_HALF[{SIDE, idx}];
         always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               cnt_q <= '0;
               tone_q <= 1'b0;
            end else if (!tone_en_q[g]) begin
               cnt_q <= '0;
               tone_q <= 1'b0;
            end else if (cnt_q >= half - 1'b1) begin
               cnt_q <= '0;
               tone_q <= ~tone_q;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
         tone_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
            tone_en_q[g] && $past(tone_en_q[g]) && cnt_q == '0 && $past(cnt_q) != '0
            |-> $past(cnt_q) == half - 1'b1 && tone_q != $past(tone_q))
            else $error("tone half period wrong");
      end
   endgenerate

   // open-drain pins only ever pull low
   assign row_o = 4'h0;
   assign col_o = 4'h0;
   assign mute_out_n_o = 1'b0;
   assign row_oe_o = row_oe_q;
   assign col_oe_o = col_oe_q;
   assign mute_out_n_oe_o = mute_oe_q;
   assign osc_run_o = osc_run_q;
   assign row_tone_o = g_div[0].tone_q;
   assign col_tone_o = g_div[1].tone_q;
   assign row_tone_en_o = tone_en_q[0];
   assign col_tone_en_o = tone_en_q[1];
   assign key_valid_o = key_valid_q;
   assign key_code_o = key_code_q;
   assign redial_o = redial_q;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   td_low_quiet_a: assert property (!tone_dis_n_i |=> !osc_run_o && row_oe_o == 4'h0 && col_oe_o == 4'h0
      && !key_valid_o && !row_tone_en_o && !col_tone_en_o)
      else $error("disabled dialer not quiet");
   idle_static_a: assert property (st_q == ST_IDLE && $past(st_q) == ST_IDLE && tone_dis_n_i
      && $past(tone_dis_n_i) && $past(reset_n_i)
      |-> !osc_run_o && col_oe_o == 4'h0 && row_oe_o == 4'hF)
      else $error("keypad not static while idle");
   mute_disabled_a: assert property (!tone_dis_n_i |=> mute_out_n_oe_o)
      else $error("mute not asserted while disabled");
   mute_release_a: assert property ($past(tone_dis_n_i) && st_q == ST_IDLE |-> !mute_out_n_oe_o)
      else $error("mute held without a key");
   qual_time_a: assert property (st_q == ST_QUAL && st_d == ST_TONE |-> qual_cnt_q >= KEY_QUALIFY_CYC_P - 1)
      else $error("key accepted before qualification time");
   single_gate_a: assert property (row_tone_en_o != col_tone_en_o |-> $past(single_tone_en_i))
      else $error("single tone without enable");
   redial_key_a: assert property (redial_o |-> key_valid_o && !row_tone_en_o && !col_tone_en_o
      && ((REDIAL_MODE == REDIAL_COL4 && key_code_o[1:0] == COL_FOURTH)
      || (REDIAL_MODE == REDIAL_HASH && key_code_o == KEY_HASH)))
      else $error("redial on wrong key");
   release_end_a: assert property (st_q == ST_TONE && eval && !same_key |=> !key_valid_o ##1 !mute_out_n_oe_o
      || !$past(tone_dis_n_i) || st_q != ST_IDLE)
      else $error("tone not ended on release");

endmodule : dtd_keypad_dialer

`default_nettype wire

//--- dv/dtd_keypad_model.sv
// dtd_keypad_model: keypad matrix and electronic drive seen at the dialer pins
`timescale 1ns/10ps
`default_nettype none
module dtd_keypad_model (
   input wire logic key_on_i,
   input wire logic [1:0] key_row_i,
   input wire logic [1:0] key_col_i,
   input wire logic [3:0] gnd_row_i,
   input wire logic [3:0] gnd_col_i,
   input wire logic [3:0] row_oe_i,
   input wire logic [3:0] col_oe_i,
   output logic [3:0] row_n_o,
   output logic [3:0] col_n_o
);
   // pull-ups hold idle lines high; a closed switch carries a low over to its partner line
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         row_n_o[i] = !(row_oe_i[i] | gnd_row_i[i] | (key_on_i && key_row_i == i && col_oe_i[key_col_i]));
         col_n_o[i] = !(col_oe_i[i] | gnd_col_i[i] | (key_on_i && key_col_i == i && row_oe_i[key_row_i]));
      end
   end
endmodule : dtd_keypad_model
`default_nettype wire

//--- dv/tb_top.sv
// tb_top: self-checking bench for the keypad tone dialer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dtd_pkg::*;
   localparam int unsigned KQ = 300;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, tone_dis_n_i = 1'b1, single_tone_en_i = 1'b0;
   logic key_on = 1'b0;
   logic [1:0] key_row = 2'h0, key_col = 2'h0;
   logic [3:0] gnd_row = 4'h0, gnd_col = 4'h0, row_n_i, col_n_i, row_oe_o, col_oe_o, key_code_o;
   logic mute_out_n_oe_o, osc_run_o, row_tone_en_o, col_tone_en_o, key_valid_o, redial_o, vprev = 1'b0;
   logic [3:0] row_o, col_o;
   logic mute_out_n_o, row_tone_o, col_tone_o;
   logic [7:0] q [$];
   logic [7:0] note;
   int err_count = 0, samples_checked = 0, cycles = 0, seed = 9505, r;

   initial begin
      forever #2 ref_clk_i = !ref_clk_i;
   end

   dtd_keypad_dialer #(.REDIAL_MODE(REDIAL_HASH), .KEY_QUALIFY_CYC_P(KQ)) u_dut (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .tone_dis_n_i(tone_dis_n_i),
      .single_tone_en_i(single_tone_en_i), .row_n_i(row_n_i), .col_n_i(col_n_i),
      .row_o(row_o), .row_oe_o(row_oe_o), .col_o(col_o), .col_oe_o(col_oe_o), .mute_out_n_o(mute_out_n_o),
      .mute_out_n_oe_o(mute_out_n_oe_o), .osc_run_o(osc_run_o), .row_tone_o(row_tone_o), .col_tone_o(col_tone_o),
      .row_tone_en_o(row_tone_en_o), .col_tone_en_o(col_tone_en_o), .key_valid_o(key_valid_o),
      .key_code_o(key_code_o), .redial_o(redial_o));

   dtd_keypad_model u_pad (.key_on_i(key_on), .key_row_i(key_row), .key_col_i(key_col),
      .gnd_row_i(gnd_row), .gnd_col_i(gnd_col), .row_oe_i(row_oe_o), .col_oe_i(col_oe_o),
      .row_n_o(row_n_i), .col_n_o(col_n_i));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // note = {skip code, redial, row tone en, col tone en, key code}; caller has set the keypad
   task automatic run_key(input logic [7:0] nt);
      int n;
      n = 0;
      q.push_back(nt);
      while (key_valid_o !== 1'b1 && n < 1200) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk({7'h0, n >= KQ && n <= KQ + 300}, 8'h01);
      key_on = 1'b0;
      gnd_row = 4'h0;
      gnd_col = 4'h0;
      n = 0;
      while (key_valid_o !== 1'b0 && n < 300) begin
         @(negedge ref_clk_i);
         n++;
      end
      @(negedge ref_clk_i);
      chk({2'h0, mute_out_n_o, row_tone_o, col_tone_o, key_valid_o, mute_out_n_oe_o, osc_run_o}, 8'h00);
      repeat (20) @(negedge ref_clk_i);
   endtask : run_key

   // monitor: each qualified entry takes the oldest note and checks what shows at the pins
   always @(negedge ref_clk_i) begin
      vprev <= key_valid_o;
      if (key_valid_o === 1'b1 && vprev !== 1'b1) begin
         if (q.size() == 0) chk(8'h01, 8'h00);
         else begin
            note = q.pop_front();
            if (!note[7]) chk({4'h0, key_code_o}, {4'h0, note[3:0]});
            chk({5'h0, redial_o, row_tone_en_o, col_tone_en_o}, {5'h0, note[6:4]});
            chk({6'h0, osc_run_o, mute_out_n_oe_o}, 8'h03);
         end
      end
   end

   // hang guard sized well above the expected run
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      repeat (3) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      repeat (20) @(negedge ref_clk_i);
      chk({2'h0, osc_run_o, mute_out_n_oe_o, row_oe_o}, 8'h0F);
      chk({row_o, col_o}, 8'h00);
      $display("test idle done");
      for (int k = 0; k < 16; k++) begin
         key_row = k[3:2];
         key_col = k[1:0];
         key_on = 1'b1;
         run_key({1'b0, (k[3:0] == KEY_HASH) ? 3'b100 : 3'b011, k[3:0]});
      end
      $display("test grid done");
      // electronic drive: dual entries, single columns and single rows in turn, random keys and enable
      for (int i = 0; i < 9; i++) begin
         r = $random(seed);
         single_tone_en_i = r[0];
         gnd_row = (i % 3 == 1) ? 4'h0 : 4'h1 << r[4:3];
         gnd_col = (i % 3 == 2) ? ~(4'h1 << r[2:1]) : 4'h1 << r[2:1];
         if (i % 3 == 0) begin
            run_key({1'b0, ({r[4:3], r[2:1]} == KEY_HASH) ? 3'b100 : 3'b011, r[4:3], r[2:1]});
         end else if (i % 3 == 1) begin
            run_key({3'b100, r[0], 4'h0});
         end else begin
            run_key({2'b10, r[0], 1'b0, 4'h0});
         end
      end
      single_tone_en_i = 1'b0;
      $display("test electronic done");
      tone_dis_n_i = 1'b0;
      key_on = 1'b1;
      repeat (700) @(negedge ref_clk_i);
      chk({1'b0, osc_run_o, key_valid_o, mute_out_n_oe_o, row_oe_o}, 8'h10);
      key_on = 1'b0;
      tone_dis_n_i = 1'b1;
      $display("test disable done");
      // a press shorter than qualification and a two-by-two entry must both be refused
      key_on = 1'b1;
      repeat (200) @(negedge ref_clk_i);
      key_on = 1'b0;
      gnd_row = 4'h3;
      gnd_col = 4'h3;
      repeat (800) @(negedge ref_clk_i);
      gnd_row = 4'h0;
      gnd_col = 4'h0;
      repeat (300) @(negedge ref_clk_i);
      chk({7'h0, key_valid_o}, 8'h00);
      chk(8'(q.size()), 8'h00);
      $display("test refuse done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
